// ===== logic/itf_core.sv
// Instruction execution core with cycle timing and status flags
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module itf_core #(
   parameter int WDT_PRESCALE = itf_pkg::ITF_WDT_PRESCALE,
   parameter int WDT_TICKS    = itf_pkg::ITF_WDT_TICKS
)(
   input  wire logic                          i_core_clk,
   input  wire logic                          i_resetn,
   input  wire logic [itf_pkg::ITF_IW-1:0]    i_pm_data,
   input  wire logic                          i_wake,
   input  wire logic [itf_pkg::ITF_RA_W-1:0]  i_reg_addr,
   input  wire logic [itf_pkg::ITF_RW-1:0]    i_reg_wdata,
   input  wire logic                          i_reg_wr,
   input  wire logic                          i_reg_rd,
   output logic [itf_pkg::ITF_PC_W-1:0]       o_pm_addr,
   output logic [itf_pkg::ITF_RW-1:0]         o_reg_rdata,
   output logic                               o_halted,
   output logic                               o_timeout_flag,
   output logic                               o_powerdown_flag,
   output logic                               o_wdt_expired
);
   import itf_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0]                 wake_sync;
      itf_state_e                 st;
      logic                       run;
      logic [ITF_PC_W-1:0]        pc;
      logic [ITF_PC_W-1:0]        ir_pc;
      logic [ITF_PC_W-1:0]        stack;
      logic [ITF_IW-1:0]          ir;
      logic                       ir_valid;
      logic [ITF_DW-1:0]          acc;
      logic                       carry;
      logic [ITF_DW-1:0]          tptr;
      logic [ITF_TH_W-1:0]        thigh;
      logic [31:0][ITF_DW-1:0]    ram;
      logic [ITF_RW-1:0]          rdata;
   } itf_core_s;

   itf_core_s                 s;
   itf_core_s                 next_s;
   logic [1:0]                rst_sync;
   logic                      rst_n;
   itf_op_e                   op;
   itf_misc_e                 misc;
   logic [ITF_MA_W-1:0]       maddr;
   logic [2:0]                bsel;
   logic [ITF_DW-1:0]         imm;
   logic [ITF_PC_W-1:0]       target;
   logic                      is_jump;
   logic                      is_call;
   logic                      wd_clear;
   logic                      wd_pre1;
   logic                      wd_pre2;
   logic                      wd_pdown;
   logic                      wd_expired;
   logic                      flag_to;
   logic                      flag_pd;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ****************************************************************
   // Submodules
   // ****************************************************************
   itf_decode u_decode (
      .i_instr  (s.ir),
      .o_op     (op),
      .o_misc   (misc),
      .o_maddr  (maddr),
      .o_bit    (bsel),
      .o_imm    (imm),
      .o_target (target),
      .o_jump   (is_jump),
      .o_call   (is_call)
   );

   itf_watchdog #(
      .PRESCALE (WDT_PRESCALE),
      .TICKS    (WDT_TICKS)
   ) u_watchdog (
      .i_core_clk       (i_core_clk),
      .i_rst_n          (rst_n),
      .i_clear          (wd_clear),
      .i_pre_first      (wd_pre1),
      .i_pre_second     (wd_pre2),
      .i_power_down     (wd_pdown),
      .o_timeout_flag   (flag_to),
      .o_powerdown_flag (flag_pd),
      .o_expired        (wd_expired)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [ITF_DW-1:0] dm_read(
      input itf_core_s          c,
      input logic [ITF_MA_W-1:0] a,
      input logic               to_f,
      input logic               pd_f);
      logic [ITF_DW-1:0] v;
      v = c.ram[a];
      case (a)
         ITF_ADDR_PC_LOW:     v = c.ir_pc[ITF_DW-1:0];
         ITF_ADDR_TABLE_PTR:  v = c.tptr;
         ITF_ADDR_TABLE_HIGH: v = {2'h0, c.thigh};
         ITF_ADDR_STATUS:     v = {5'h00, to_f, pd_f, c.carry};
         default:             v = c.ram[a];
      endcase
      return v;
   endfunction

   function automatic logic [ITF_DW-1:0] bit_mask(input logic [2:0] b);
      return ITF_DW'(1) << b;
   endfunction

   // ****************************************************************
   // Execute and fetch
   // ****************************************************************
   always_comb begin
      logic [ITF_DW-1:0] mval;
      logic [ITF_DW-1:0] wb_data;
      logic [ITF_DW-1:0] adj;
      logic              wb_en;
      logic              skip;
      logic              branch;
      logic              table_rd;
      logic [ITF_PC_W-1:0] new_pc;
      mval     = dm_read(s, maddr, flag_to, flag_pd);
      wb_data  = ITF_BYTE_ZERO;
      adj      = ITF_BYTE_ZERO;
      wb_en    = 1'b0;
      skip     = 1'b0;
      branch   = 1'b0;
      table_rd = 1'b0;
      new_pc   = s.pc;
      wd_clear = 1'b0;
      wd_pre1  = 1'b0;
      wd_pre2  = 1'b0;
      wd_pdown = 1'b0;
      next_s   = s;
      next_s.wake_sync = {s.wake_sync[0], i_wake};
      next_s.rdata = '0;
      o_pm_addr = s.pc;

      if (s.st == ST_HALT) begin
         // Wake by pin or watchdog expiry
         if (s.wake_sync[1] || wd_expired) begin
            next_s.st = ST_RUN;
         end
      end else if (s.run && !s.ir_valid) begin
         // Dummy slot refills the pipeline
         next_s.ir       = i_pm_data;
         next_s.ir_pc    = s.pc;
         next_s.ir_valid = 1'b1;
         next_s.pc       = s.pc + 1'b1;
      end else if (s.run) begin
         if (is_jump) begin
            // jump or call with dummy slot
            branch = 1'b1;
            new_pc = target;
            if (is_call) begin
               next_s.stack = s.ir_pc + 1'b1;
            end
         end else begin
            case (op)
               OP_MOV_ACC_MEM: next_s.acc = mval;
               OP_MOV_MEM_ACC: begin
                  wb_en   = 1'b1;
                  wb_data = s.acc;
               end
               OP_MOV_ACC_IMM: next_s.acc = imm;
               OP_RET_IMM: begin
                  next_s.acc = imm;
                  branch     = 1'b1;
                  new_pc     = s.stack;
               end
               OP_ROT_R: begin
                  wb_en   = 1'b1;
                  wb_data = {mval[0], mval[7:1]};
               end
               OP_ROT_R_ACC: next_s.acc = {mval[0], mval[7:1]};
               OP_ROT_L: begin
                  wb_en   = 1'b1;
                  wb_data = {mval[6:0], mval[7]};
               end
               OP_ROT_L_ACC: next_s.acc = {mval[6:0], mval[7]};
               OP_ROT_RC: begin
                  wb_en        = 1'b1;
                  wb_data      = {s.carry, mval[7:1]};
                  next_s.carry = mval[0];
               end
               OP_ROT_RC_ACC: begin
                  next_s.acc   = {s.carry, mval[7:1]};
                  next_s.carry = mval[0];
               end
               OP_ROT_LC: begin
                  wb_en        = 1'b1;
                  wb_data      = {mval[6:0], s.carry};
                  next_s.carry = mval[7];
               end
               OP_ROT_LC_ACC: begin
                  next_s.acc   = {mval[6:0], s.carry};
                  next_s.carry = mval[7];
               end
               OP_BIT_CLEAR: begin
                  wb_en   = 1'b1;
                  wb_data = mval & ~bit_mask(bsel);
               end
               OP_BIT_FORCE: begin
                  wb_en   = 1'b1;
                  wb_data = mval | bit_mask(bsel);
               end
               OP_SKIP_ZERO: skip = (mval == ITF_BYTE_ZERO);
               OP_SKIP_ZERO_COPY: begin
                  next_s.acc = mval;
                  skip       = (mval == ITF_BYTE_ZERO);
               end
               OP_SKIP_BIT_ZERO: skip = ~mval[bsel];
               OP_SKIP_BIT_ONE:  skip = mval[bsel];
               OP_INC_SKIP, OP_INC_SKIP_ACC,
               OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
                  if (op == OP_INC_SKIP || op == OP_INC_SKIP_ACC) begin
                     adj = mval + 1'b1;
                  end else begin
                     adj = mval - 1'b1;
                  end
                  skip = (adj == ITF_BYTE_ZERO);
                  if (op == OP_INC_SKIP || op == OP_DEC_SKIP) begin
                     wb_en   = 1'b1;
                     wb_data = adj;
                  end else begin
                     next_s.acc = adj;
                  end
               end
               OP_TABLE_CUR, OP_TABLE_LAST: begin
                  table_rd  = 1'b1;
                  o_pm_addr = {(op == OP_TABLE_LAST) ? ITF_LAST_PAGE
                               : s.ir_pc[ITF_PC_W-1:ITF_DW], s.tptr};
                  next_s.thigh = i_pm_data[ITF_IW-1:ITF_DW];
                  wb_en   = 1'b1;
                  wb_data = i_pm_data[ITF_DW-1:0];
               end
               OP_BYTE_CLEAR: begin
                  wb_en   = 1'b1;
                  wb_data = ITF_BYTE_ZERO;
               end
               OP_BYTE_FORCE: begin
                  wb_en   = 1'b1;
                  wb_data = ITF_BYTE_ONES;
               end
               OP_NIBBLE: begin
                  wb_en   = 1'b1;
                  wb_data = {mval[3:0], mval[7:4]};
               end
               OP_NIBBLE_ACC: next_s.acc = {mval[3:0], mval[7:4]};
               OP_MISC: begin
                  case (misc)
                     MI_RETURN, MI_INT_RETURN: begin
                        branch = 1'b1;
                        new_pc = s.stack;
                     end
                     MI_WD_CLEAR:      wd_clear = 1'b1;
                     MI_WD_PRE_FIRST:  wd_pre1  = 1'b1;
                     MI_WD_PRE_SECOND: wd_pre2  = 1'b1;
                     MI_POWER_DOWN: begin
                        wd_pdown  = 1'b1;
                        next_s.st = ST_HALT;
                     end
                     default: ;
                  endcase
               end
               default: ;
            endcase
         end

         // Data memory and special register writes
         if (wb_en) begin
            case (maddr)
               ITF_ADDR_PC_LOW: begin
                  branch = 1'b1;
                  new_pc = {s.ir_pc[ITF_PC_W-1:ITF_DW], wb_data};
               end
               ITF_ADDR_TABLE_PTR:  next_s.tptr = wb_data;
               ITF_ADDR_TABLE_HIGH: ;
               ITF_ADDR_STATUS:
                  next_s.carry = wb_data[ITF_FLAG_CARRY_BIT];
               default: next_s.ram[maddr] = wb_data;
            endcase
         end

         // taken skip adds a dummy slot
         if (branch || skip || table_rd) begin
            next_s.ir_valid = 1'b0;
         end
         if (branch) begin
            next_s.pc = new_pc;
         end else if (!table_rd) begin
            next_s.ir    = i_pm_data;
            next_s.ir_pc = s.pc;
            next_s.pc    = s.pc + 1'b1;
         end
      end

      // Software register port
      if (i_reg_wr && i_reg_addr == ITF_REG_CTRL) begin
         next_s.run = i_reg_wdata[ITF_CTRL_RUN_BIT];
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            ITF_REG_CTRL:  next_s.rdata[ITF_CTRL_RUN_BIT] = s.run;
            ITF_REG_FLAGS: begin
               next_s.rdata[ITF_FLAG_CARRY_BIT] = s.carry;
               next_s.rdata[ITF_FLAG_PWRDN_BIT] = flag_pd;
               next_s.rdata[ITF_FLAG_TIMEO_BIT] = flag_to;
               next_s.rdata[ITF_FLAG_HALT_BIT]  = (s.st == ST_HALT);
            end
            ITF_REG_ACC: next_s.rdata = {8'h00, s.acc};
            ITF_REG_PC:  next_s.rdata = {6'h00, s.ir_pc};
            default:     next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{default: '0, st: ST_RUN, run: ITF_CTRL_RUN_RST};
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_reg_rdata      = s.rdata;
   assign o_halted         = (s.st == ST_HALT);
   assign o_timeout_flag   = flag_to;
   assign o_powerdown_flag = flag_pd;
   assign o_wdt_expired    = wd_expired;

endmodule // itf_core

// ===== logic/itf_pkg.sv
// Shared constants and types for the instruction timing and flags core
package itf_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int ITF_IW   = 14;
   localparam int ITF_DW   = 8;
   localparam int ITF_PC_W = 10;
   localparam int ITF_MA_W = 5;
   localparam int ITF_RW   = 16;
   localparam int ITF_RA_W = 4;
   localparam int ITF_TH_W = 6;

   // ****************************************************************
   // Special data memory addresses
   // ****************************************************************
   localparam logic [4:0] ITF_ADDR_PC_LOW     = 5'h02;
   localparam logic [4:0] ITF_ADDR_TABLE_PTR  = 5'h03;
   localparam logic [4:0] ITF_ADDR_TABLE_HIGH = 5'h04;
   localparam logic [4:0] ITF_ADDR_STATUS     = 5'h05;

   // ****************************************************************
   // Software register port
   // ****************************************************************
   localparam logic [3:0] ITF_REG_CTRL  = 4'h0;
   localparam logic [3:0] ITF_REG_FLAGS = 4'h1;
   localparam logic [3:0] ITF_REG_ACC   = 4'h2;
   localparam logic [3:0] ITF_REG_PC    = 4'h3;
   localparam int         ITF_CTRL_RUN_BIT   = 0;
   localparam logic       ITF_CTRL_RUN_RST   = 1'b1;
   localparam int         ITF_FLAG_CARRY_BIT = 0;
   localparam int         ITF_FLAG_PWRDN_BIT = 1;
   localparam int         ITF_FLAG_TIMEO_BIT = 2;
   localparam int         ITF_FLAG_HALT_BIT  = 3;

   // ****************************************************************
   // Instruction fields
   // ****************************************************************
   localparam int         ITF_JUMP_BIT = 13;
   localparam int         ITF_CALL_BIT = 12;
   localparam int         ITF_OPC_LSB  = 8;
   localparam int         ITF_BIT_LSB  = 5;
   localparam logic [1:0] ITF_LAST_PAGE = 2'h3;
   localparam logic [7:0] ITF_BYTE_ZERO = 8'h00;
   localparam logic [7:0] ITF_BYTE_ONES = 8'hFF;

   // ****************************************************************
   // Watchdog timing
   // ****************************************************************
   localparam int ITF_WDT_PRESCALE = 64;
   localparam int ITF_WDT_TICKS    = 256;

   typedef enum logic [4:0] {
      OP_MISC, OP_MOV_ACC_MEM, OP_MOV_MEM_ACC, OP_MOV_ACC_IMM,
      OP_RET_IMM, OP_ROT_R, OP_ROT_R_ACC, OP_ROT_RC, OP_ROT_RC_ACC,
      OP_ROT_L, OP_ROT_L_ACC, OP_ROT_LC, OP_ROT_LC_ACC, OP_BIT_CLEAR,
      OP_BIT_FORCE, OP_SKIP_ZERO, OP_SKIP_ZERO_COPY, OP_SKIP_BIT_ZERO,
      OP_SKIP_BIT_ONE, OP_INC_SKIP, OP_DEC_SKIP, OP_INC_SKIP_ACC,
      OP_DEC_SKIP_ACC, OP_TABLE_CUR, OP_TABLE_LAST, OP_BYTE_CLEAR,
      OP_BYTE_FORCE, OP_NIBBLE, OP_NIBBLE_ACC
   } itf_op_e;

   typedef enum logic [2:0] {
      MI_NOP, MI_RETURN, MI_INT_RETURN, MI_WD_CLEAR,
      MI_WD_PRE_FIRST, MI_WD_PRE_SECOND, MI_POWER_DOWN
   } itf_misc_e;

   typedef enum logic {ST_RUN, ST_HALT} itf_state_e;

endpackage

// ===== logic/itf_decode.sv
// Instruction word decoder
`timescale 1ns/1ns
module itf_decode (
   input  wire logic [itf_pkg::ITF_IW-1:0]   i_instr,
   output itf_pkg::itf_op_e                  o_op,
   output itf_pkg::itf_misc_e                o_misc,
   output logic [itf_pkg::ITF_MA_W-1:0]      o_maddr,
   output logic [2:0]                        o_bit,
   output logic [itf_pkg::ITF_DW-1:0]        o_imm,
   output logic [itf_pkg::ITF_PC_W-1:0]      o_target,
   output logic                              o_jump,
   output logic                              o_call
);
   import itf_pkg::*;

   // ****************************************************************
   // Opcode mapping, unknown codes decode as miscellaneous ops picked by the low three bits
   // ****************************************************************
   function automatic itf_op_e op_of(input logic [ITF_IW-1:0] w);
      logic [4:0] raw;
      raw = w[ITF_OPC_LSB +: 5];
      if (w[ITF_JUMP_BIT] || raw > OP_NIBBLE_ACC) begin
         return OP_MISC;
      end
      return itf_op_e'(raw);
   endfunction

   function automatic itf_misc_e misc_of(input logic [ITF_IW-1:0] w);
      if (w[2:0] > MI_POWER_DOWN) begin
         return MI_NOP;
      end
      return itf_misc_e'(w[2:0]);
   endfunction

   always_comb begin
      o_op     = op_of(i_instr);
      o_misc   = misc_of(i_instr);
      o_maddr  = i_instr[ITF_MA_W-1:0];
      o_bit    = i_instr[ITF_BIT_LSB +: 3];
      o_imm    = i_instr[ITF_DW-1:0];
      o_target = i_instr[ITF_PC_W-1:0];
      o_jump   = i_instr[ITF_JUMP_BIT];
      o_call   = i_instr[ITF_JUMP_BIT] & i_instr[ITF_CALL_BIT];
   end

endmodule // itf_decode

// ===== logic/itf_watchdog.sv
// Watchdog counter with time-out and power-down flags
`timescale 1ns/1ns
module itf_watchdog #(
   parameter int PRESCALE = itf_pkg::ITF_WDT_PRESCALE,
   parameter int TICKS    = itf_pkg::ITF_WDT_TICKS
)(
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_clear,
   input  wire logic i_pre_first,
   input  wire logic i_pre_second,
   input  wire logic i_power_down,
   output logic      o_timeout_flag,
   output logic      o_powerdown_flag,
   output logic      o_expired
);
   import itf_pkg::*;

   localparam int PW = $clog2(PRESCALE);
   localparam int CW = $clog2(TICKS);

   if (PRESCALE < 2 || TICKS < 2) begin : g_chk
      $error("itf_watchdog: PRESCALE and TICKS must be at least 2");
   end

   typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} itf_pre_e;

   typedef struct packed {
      logic [PW-1:0] presc;
      logic [CW-1:0] count;
      itf_pre_e      last;
      logic          timeout;
      logic          pwrdn;
      logic          expired;
   } itf_wd_s;

   itf_wd_s s;
   itf_wd_s next_s;
   logic    effective;
   logic    tick;

   always_comb begin
      next_s = s;
      next_s.expired = 1'b0;
      effective = i_clear
                | (i_pre_first && s.last == PRE_SECOND)
                | (i_pre_second && s.last == PRE_FIRST);
      if (effective) begin
         next_s.last = PRE_NONE;
      end else if (i_pre_first) begin
         next_s.last = PRE_FIRST;
      end else if (i_pre_second) begin
         next_s.last = PRE_SECOND;
      end
      tick = (s.presc == PW'(PRESCALE - 1));
      next_s.presc = tick ? '0 : s.presc + 1'b1;
      if (tick) begin
         next_s.count = s.count + 1'b1;
      end
      if (effective) begin
         next_s.count   = '0;
         next_s.timeout = 1'b0;
         next_s.pwrdn   = 1'b0;
      end
      if (i_power_down) begin
         next_s.count   = '0;
         next_s.presc   = '0;
         next_s.timeout = 1'b0;
         next_s.pwrdn   = 1'b1;
      end else if (tick && s.count == CW'(TICKS - 1)) begin
         next_s.count   = '0;
         next_s.timeout = 1'b1;
         next_s.expired = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '{default: '0, last: PRE_NONE};
      end else begin
         s <= next_s;
      end
   end

   assign o_timeout_flag   = s.timeout;
   assign o_powerdown_flag = s.pwrdn;
   assign o_expired        = s.expired;

endmodule // itf_watchdog

// ===== sim/itf_core_chk.sv
// Port checker for the instruction core
`timescale 1ns/1ns
module itf_core_chk (
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_reg_rd,
   input  wire logic        i_wake,
   input  wire logic [15:0] o_reg_rdata,
   input  wire logic [9:0]  o_pm_addr,
   input  wire logic        o_halted,
   input  wire logic        o_timeout_flag,
   input  wire logic        o_powerdown_flag,
   input  wire logic        o_wdt_expired
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   AST_RD_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   AST_HALT_FLAGS: assert property ($rose(o_halted) |->
      o_powerdown_flag && !o_timeout_flag) else $error("halt flags wrong");
   AST_HALT_HOLD: assert property (o_halted && $past(o_halted) |->
      $stable(o_pm_addr)) else $error("fetch moved in halt");
   AST_PD_SRC: assert property ($rose(o_powerdown_flag) |-> o_halted)
      else $error("powerdown flag without halt");
   AST_HALT_PD: assert property (o_halted |-> o_powerdown_flag)
      else $error("powerdown flag lost in halt");
   AST_TO_SRC: assert property ($rose(o_timeout_flag) |->
      o_wdt_expired || $past(o_wdt_expired)) else $error("timeout unasked");
   AST_EXP_PULSE: assert property (o_wdt_expired |=> !o_wdt_expired)
      else $error("expiry pulse too long");
   AST_WAKE: assert property (o_halted && i_wake |-> ##[1:4] !o_halted)
      else $error("no wake");
endmodule // itf_core_chk
bind itf_core itf_core_chk itf_core_chk_inst (.i_core_clk(i_core_clk),
   .i_resetn(i_resetn), .i_reg_rd(i_reg_rd), .i_wake(i_wake),
   .o_reg_rdata(o_reg_rdata), .o_pm_addr(o_pm_addr), .o_halted(o_halted),
   .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag),
   .o_wdt_expired(o_wdt_expired));

// ===== sim/itf_core_tb.sv
// Testbench for the instruction core
`timescale 1ns/1ns
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin n_fail++; \
$display("BAD %s exp %h got %h", n, e, g); end end
module itf_core_tb;
   import itf_pkg::*;
   logic        clk = 0, rstn = 0, wake = 0, wr = 0, rd = 0;
   logic [3:0]  ra = 4'h0;
   logic [15:0] wd = 16'h0000, rdat, rq;
   logic [9:0]  pa;
   logic [13:0] rom [0:1023];
   logic        hl, tf, pf, ex;
   int          n_fail = 0, checked = 0, cyc = 0, seen [0:1023];
   int          slt [12][3] = '{'{1,21,2}, '{21,2,2}, '{2,7,5}, '{7,8,1},
                               '{8,10,2}, '{10,13,2}, '{14,16,2}, '{16,256,2},
                               '{261,262,2}, '{262,263,2}, '{261,288,1},
                               '{262,800,1}};
   always #50 clk = ~clk;
   itf_core #(.WDT_PRESCALE(4), .WDT_TICKS(16)) itf_core_inst (
      .i_core_clk(clk), .i_resetn(rstn), .i_pm_data(rom[pa]), .i_wake(wake),
      .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
      .o_pm_addr(pa), .o_reg_rdata(rdat), .o_halted(hl),
      .o_timeout_flag(tf), .o_powerdown_flag(pf), .o_wdt_expired(ex));
   function automatic logic [13:0] ins(itf_op_e o, logic [7:0] f);
      return {1'b0, o, f};
   endfunction
   task automatic rg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk) begin rd <= 1'b1; ra <= a; end
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) d = rdat;
   endtask
   task automatic wg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) begin wr <= 1'b1; ra <= a; wd <= d; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic upto(input int a);
      repeat (400) if (pa !== 10'(a)) @(negedge clk);
   endtask
   task automatic results;
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (seen[pa] == 0) seen[pa] = cyc;
   end
   initial begin #400000; n_fail++; results; end
   initial begin
      foreach (rom[i]) rom[i] = 14'h0000;
      foreach (seen[i]) seen[i] = 0;
      rom[0] = 14'h3014;
      rom[20] = ins(OP_RET_IMM, 8'h5A);
      rom[1] = ins(OP_BYTE_FORCE, 8'h08);
      rom[2] = ins(OP_BIT_CLEAR, 8'h08);
      rom[3] = ins(OP_ROT_LC, 8'h08);
      rom[4] = ins(OP_ROT_R, 8'h08);
      rom[5] = ins(OP_NIBBLE, 8'h08);
      rom[6] = ins(OP_INC_SKIP_ACC, 8'h08);
      rom[7] = ins(OP_SKIP_BIT_ZERO, 8'h68);
      rom[8] = ins(OP_MOV_ACC_IMM, 8'h00);
      rom[9] = 14'h200C;
      rom[12] = ins(OP_BYTE_CLEAR, 8'h09);
      rom[13] = ins(OP_SKIP_ZERO, 8'h09);
      rom[14] = ins(OP_MOV_ACC_IMM, 8'h00);
      rom[15] = ins(OP_BYTE_FORCE, 8'h02);
      rom[255] = ins(OP_MISC, {5'h00, MI_POWER_DOWN});
      rom[256] = ins(OP_MISC, {5'h00, MI_WD_PRE_FIRST});
      rom[257] = ins(OP_MISC, {5'h00, MI_WD_PRE_FIRST});
      rom[258] = ins(OP_MISC, {5'h00, MI_WD_PRE_SECOND});
      rom[259] = ins(OP_MOV_ACC_IMM, 8'h20);
      rom[260] = ins(OP_MOV_MEM_ACC, 8'h03);
      rom[261] = ins(OP_TABLE_CUR, 8'h0B);
      rom[262] = ins(OP_TABLE_LAST, 8'h0A);
      rom[263] = ins(OP_BIT_FORCE, 8'hE9);
      rom[264] = ins(OP_SKIP_BIT_ONE, 8'hE9);
      rom[265] = ins(OP_BYTE_CLEAR, 8'h0A);
      rom[266] = ins(OP_SKIP_ZERO_COPY, 8'h0A);
      rom[267] = ins(OP_ROT_RC, 8'h04);
      rom[268] = ins(OP_MISC, {5'h00, MI_WD_CLEAR});
      rom[269] = 14'h210D;
      rom[800] = 14'h143C;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      upto(256);
      repeat (4) @(negedge clk);
      `CHK("halted", 1'b1, hl)
      `CHK("pdf", 1'b1, pf)
      `CHK("tof", 1'b0, tf)
      rg(ITF_REG_ACC, rq);
      `CHK("acc", 16'h00E8, rq)
      rg(ITF_REG_FLAGS, rq);
      `CHK("flags", 16'h000B, rq)
      @(posedge clk) wake <= 1'b1;
      upto(259);
      `CHK("pdf pair", 1'b1, pf)
      @(posedge clk) wake <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK("pdf clr", 1'b0, pf)
      upto(269);
      wg(ITF_REG_CTRL, 16'h0000);
      repeat (300) if (ex !== 1'b1) @(negedge clk);
      @(negedge clk);
      `CHK("tof exp", 1'b1, tf)
      rg(ITF_REG_FLAGS, rq);
      `CHK("flags exp", 16'h0004, rq)
      rg(ITF_REG_ACC, rq);
      `CHK("acc tbl", 16'h003C, rq)
      rg(4'hF, rq);
      `CHK("unmapped", 16'h0000, rq)
      for (int i = 0; i < 12; i++)
         `CHK("slots", slt[i][2], seen[slt[i][1]] - seen[slt[i][0]])
      results;
   end
endmodule // itf_core_tb
